// [hdl/gsl_pkg.sv]
// shared constants, register map and state types of the group selector
package gsl_pkg;

  localparam int unsigned GSL_NUM_GROUPS = 8;

  // register byte offsets
  localparam logic [11:0] GSL_OFS_CTRL = 12'h000;
  localparam logic [11:0] GSL_OFS_FORCE = 12'h004;
  localparam logic [11:0] GSL_OFS_REMOTE = 12'h008;
  localparam logic [11:0] GSL_OFS_STATUS = 12'h00c;

  // field positions
  localparam int unsigned GSL_CTRL_FEN_BIT = 0;
  localparam int unsigned GSL_CTRL_CNT_LSB = 4;
  localparam int unsigned GSL_ST_ACT_LSB = 0;
  localparam int unsigned GSL_ST_REQ_LSB = 8;
  localparam int unsigned GSL_ST_FLAG_LSB = 16;
  localparam int unsigned GSL_ST_FEN_BIT = 20;

  // sticky failure flag indices
  localparam int unsigned GSL_FL_NOCFG = 0;
  localparam int unsigned GSL_FL_LOWPRI = 1;
  localparam int unsigned GSL_FL_FORCE = 2;

  // encodings and reset values
  localparam logic [3:0] GSL_GROUP_NONE = 4'h0;
  localparam logic [3:0] GSL_GROUP_ONE = 4'h1;
  localparam logic [3:0] GSL_GROUP_EIGHT = 4'h8;
  localparam logic [3:0] GSL_CNT_RST = 4'h1;

  typedef enum logic {
    GSL_AUTO,
    GSL_FORCED
  } gsl_mode_t;

  typedef struct packed {
    gsl_mode_t mode;
    logic [7:0] req_prev;
    logic [3:0] active;
    logic [3:0] count;
    logic [3:0] forced_val;
    logic [3:0] remote_val;
    logic [2:0] sticky;
    logic [2:0] fail_pulse;
    logic [7:0] dflt_load;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } gsl_state_t;

  // one-hot group bit for an index 1..8, zero for none or out of range
  function automatic logic [7:0] gsl_onehot(input logic [3:0] v);
    logic [7:0] r;
    r = 8'h00;
    if (v >= GSL_GROUP_ONE && v <= GSL_GROUP_EIGHT) begin
      r = 8'h01 << (v - GSL_GROUP_ONE);
    end
    return r;
  endfunction

  // enabled groups for a used-group count, always from group one upward
  function automatic logic [7:0] gsl_count_mask(input logic [3:0] c);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = (c > 4'(i));
    end
    return r;
  endfunction

endpackage

// [hdl/gsl_group_selector.sv]
// setting group selector with apb register access
// How it works
// - up to eight groups; active group encoded as index one to eight
// - after reset only group one enabled and active; selector then idle
// - with several groups enabled, requests pick the active group
// - force mode ignores automatic requests until force-enable is cleared
// - each request input may pulse or hold a level, freely mixed
// - simultaneous requests: highest-priority requested group wins
// - group one highest priority, falling down to group eight
// - pulse-activated group stays active until another group is requested
// - forced change needs force-enable on and an enabled target
// - held level requests regain control when force-enable is released
// - active group status readable, one to eight, group one after reset
// - forced group is none or one to eight, default none, pulse style
// - leaving force with no request keeps the last forced group
// - force-enable resets off; force writes rejected while it is off
// - used-group count enables groups from one; new ones load defaults
// - remote request none or one to eight; blocked by held higher group
// - held group one level blocks every other request
// - held level on groups two to seven blocks all lower groups
// - held group eight level blocks nothing
// - request for a group beyond the count is refused, flag raised
// - request blocked by higher held group raises lower-priority flag
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module gsl_group_selector
  import gsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [7:0] group_req,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [3:0] active_group_index,
  output logic force_enable,
  output logic fail_not_configured,
  output logic fail_lower_priority,
  output logic fail_force,
  output logic [7:0] default_load
);

  localparam gsl_state_t GSL_RST = '{
    mode: GSL_AUTO,
    req_prev: 8'h00,
    active: GSL_GROUP_ONE,
    count: GSL_CNT_RST,
    forced_val: GSL_GROUP_NONE,
    remote_val: GSL_GROUP_NONE,
    sticky: 3'h0,
    fail_pulse: 3'h0,
    dflt_load: 8'h00,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000
  };

  gsl_state_t st_r;
  gsl_state_t st_nxt;

  logic [7:0] en_mask;
  logic [7:0] blk;

  assign en_mask = gsl_count_mask(st_r.count);

  // a level only blocks groups below it, so group eight blocks none
  for (genvar g = 0; g < GSL_NUM_GROUPS; g++) begin : g_blk
    localparam logic [7:0] HIGHER = 8'((1 << g) - 1);
    assign blk[g] = |(group_req & HIGHER);
  end

  always_comb begin
    logic acc;
    logic wr;
    logic mapped;
    logic wr_ctrl;
    logic wr_force;
    logic wr_remote;
    logic force_off;
    logic auto_on;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] remote_oh;
    logic [7:0] force_oh;
    logic [7:0] auto_ev;
    logic [7:0] real_ev;
    logic [7:0] cand;
    logic [7:0] new_mask;
    logic [3:0] pick;
    logic [3:0] new_cnt;
    logic [2:0] set_fl;
    logic [2:0] clr_fl;
    logic [31:0] rd;
    acc = 1'b0;
    wr = 1'b0;
    mapped = 1'b0;
    wr_ctrl = 1'b0;
    wr_force = 1'b0;
    wr_remote = 1'b0;
    force_off = 1'b0;
    auto_on = 1'b0;
    rise = 8'h00;
    fall = 8'h00;
    remote_oh = 8'h00;
    force_oh = 8'h00;
    auto_ev = 8'h00;
    real_ev = 8'h00;
    cand = 8'h00;
    new_mask = 8'h00;
    pick = GSL_GROUP_NONE;
    new_cnt = 4'h0;
    set_fl = 3'h0;
    clr_fl = 3'h0;
    rd = 32'h0000_0000;

    st_nxt = st_r;
    st_nxt.fail_pulse = 3'h0;
    st_nxt.dflt_load = 8'h00;

    // apb decode; pready is only ever high in the access phase
    mapped = (paddr == GSL_OFS_CTRL) || (paddr == GSL_OFS_FORCE) ||
             (paddr == GSL_OFS_REMOTE) || (paddr == GSL_OFS_STATUS);
    acc = psel && penable && st_r.pready;
    wr = acc && pwrite && mapped;
    wr_ctrl = wr && (paddr == GSL_OFS_CTRL);
    wr_force = wr && (paddr == GSL_OFS_FORCE);
    wr_remote = wr && (paddr == GSL_OFS_REMOTE);

    case (paddr)
      GSL_OFS_CTRL: begin
        rd[GSL_CTRL_FEN_BIT] = (st_r.mode == GSL_FORCED);
        rd[GSL_CTRL_CNT_LSB +: 4] = st_r.count;
      end
      GSL_OFS_FORCE: begin
        rd[3:0] = st_r.forced_val;
      end
      GSL_OFS_REMOTE: begin
        rd[3:0] = st_r.remote_val;
      end
      GSL_OFS_STATUS: begin
        rd[GSL_ST_ACT_LSB +: 4] = st_r.active;
        rd[GSL_ST_REQ_LSB +: 8] = group_req;
        rd[GSL_ST_FLAG_LSB +: 3] = st_r.sticky;
        rd[GSL_ST_FEN_BIT] = (st_r.mode == GSL_FORCED);
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase

    if (psel && !penable) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = rd;
      st_nxt.pslverr = !mapped;
    end else if (acc) begin
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
    end

    // request events
    rise = group_req & ~st_r.req_prev;
    fall = ~group_req & st_r.req_prev;
    st_nxt.req_prev = group_req;
    force_off = wr_ctrl && (st_r.mode == GSL_FORCED) && !pwdata[GSL_CTRL_FEN_BIT];
    auto_on = (st_r.mode == GSL_AUTO) || force_off;
    if (wr_remote) begin
      st_nxt.remote_val = pwdata[3:0];
      remote_oh = gsl_onehot(pwdata[3:0]);
    end

    // held levels are re-judged when force ends or any request line drops
    real_ev = rise | remote_oh;
    auto_ev = real_ev | (group_req & {8{force_off || (|fall)}});

    if (auto_on) begin
      cand = auto_ev & en_mask & ~blk;
      for (int i = 7; i >= 0; i--) begin
        if (cand[i]) begin
          pick = 4'(i + 1);
        end
      end
      // no event leaves the current group in place
      if (pick != GSL_GROUP_NONE) begin
        st_nxt.active = pick;
      end
      set_fl[GSL_FL_NOCFG] = |(real_ev & ~en_mask);
      set_fl[GSL_FL_LOWPRI] = |(real_ev & en_mask & blk);
    end

    // forced selection acts once per write, never as a level
    if (wr_force) begin
      st_nxt.forced_val = pwdata[3:0];
      force_oh = gsl_onehot(pwdata[3:0]);
      if ((st_r.mode == GSL_FORCED) && (|(force_oh & en_mask))) begin
        st_nxt.active = pwdata[3:0];
      end else if (pwdata[3:0] != GSL_GROUP_NONE) begin
        set_fl[GSL_FL_FORCE] = 1'b1;
      end
    end

    if (wr_ctrl) begin
      st_nxt.mode = pwdata[GSL_CTRL_FEN_BIT] ? GSL_FORCED : GSL_AUTO;
      new_cnt = pwdata[GSL_CTRL_CNT_LSB +: 4];
      // out-of-range counts are ignored rather than clipped
      if (new_cnt >= GSL_GROUP_ONE && new_cnt <= GSL_GROUP_EIGHT) begin
        st_nxt.count = new_cnt;
        new_mask = gsl_count_mask(new_cnt);
        st_nxt.dflt_load = new_mask & ~en_mask;
        if (st_nxt.active > new_cnt) begin
          st_nxt.active = GSL_GROUP_ONE;
        end
      end
    end

    // status flags: write one to clear, a new event wins over the clear
    if (wr && (paddr == GSL_OFS_STATUS)) begin
      clr_fl = pwdata[GSL_ST_FLAG_LSB +: 3];
    end
    st_nxt.sticky = (st_r.sticky & ~clr_fl) | set_fl;
    st_nxt.fail_pulse = set_fl;
  end

  // clk_en low freezes everything, including an apb transfer in flight
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= GSL_RST;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign active_group_index = st_r.active;
  assign force_enable = (st_r.mode == GSL_FORCED);
  assign fail_not_configured = st_r.fail_pulse[GSL_FL_NOCFG];
  assign fail_lower_priority = st_r.fail_pulse[GSL_FL_LOWPRI];
  assign fail_force = st_r.fail_pulse[GSL_FL_FORCE];
  assign default_load = st_r.dflt_load;

endmodule // gsl_group_selector

// [test/gsl_req_model.sv]
// request source model: internal logic driving the group request lines
`timescale 1ns/1ns
module gsl_req_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] level_set,
  input wire logic [7:0] pulse_set,
  output logic [7:0] group_req
);
  // pulses last one clock, levels hold; both may mix across lines
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      group_req <= 8'h00;
    end else begin
      group_req <= level_set | pulse_set;
    end
  end
endmodule // gsl_req_model

// [test/gsl_group_selector_monitor.sv]
// port checker for the group selector
`timescale 1ns/1ns
module gsl_sel_monitor
  import gsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [7:0] group_req,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [3:0] active_group_index,
  input wire logic force_enable,
  input wire logic fail_force,
  input wire logic [7:0] default_load
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence quiet_s;
    $past(nrst) && $past(clk_en) && clk_en && !force_enable && !psel && $stable(group_req);
  endsequence
  act_range_a: assert property (active_group_index inside {[4'h1:4'h8]})
    else $error("active group out of range");
  reset_one_a: assert property ($rose(nrst) |-> active_group_index == 4'h1 && !force_enable)
    else $error("reset state wrong");
  bus_ready_a: assert property (clk_en && psel && !penable |=> pready)
    else $error("no ready after setup");
  force_hold_a: assert property (force_enable && !psel |=> $stable(active_group_index))
    else $error("active moved in force mode");
  force_rej_a: assert property (clk_en && !force_enable && psel && penable && pready && pwrite
    && paddr == GSL_OFS_FORCE && pwdata[3:0] != 4'h0 |=> fail_force)
    else $error("force write not refused");
  top_group_a: assert property ($past(clk_en) && clk_en && !force_enable && $rose(group_req[0])
    |=> active_group_index == 4'h1)
    else $error("group one request lost");
  idle_hold_a: assert property (quiet_s |=> $stable(active_group_index))
    else $error("active moved without cause");
  new_dflt_a: assert property (|default_load |-> $past(psel && pwrite && paddr == GSL_OFS_CTRL))
    else $error("default load without count write");
endmodule // gsl_sel_monitor
bind gsl_group_selector gsl_sel_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
  .group_req(group_req), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .active_group_index(active_group_index),
  .force_enable(force_enable), .fail_force(fail_force), .default_load(default_load));

// [test/gsl_group_selector_bench.sv]
// self-checking bench for the group selector
`timescale 1ns/1ns
module gsl_group_selector_bench;
  import gsl_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, force_enable;
  logic [7:0] group_req, lvl = 8'h00, pls = 8'h00;
  logic [3:0] active_group_index;
  logic [7:0] dload, dl_acc = 8'h00;
  logic [2:0] fl_acc = 3'h0;
  logic fl_nc, fl_lp, fl_fc;
  int mismatches = 0;
  int samples_checked = 0;
  always #4 clk_sys = ~clk_sys;
  gsl_req_model u_src (.clk_sys(clk_sys), .nrst(nrst), .level_set(lvl), .pulse_set(pls),
    .group_req(group_req));
  gsl_group_selector u_dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .group_req(group_req),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .active_group_index(active_group_index),
    .force_enable(force_enable), .fail_not_configured(fl_nc), .fail_lower_priority(fl_lp),
    .fail_force(fl_fc), .default_load(dload));
  // one-cycle pulses are gathered so no pulse escapes the checks
  always @(posedge clk_sys) begin
    dl_acc <= dl_acc | dload;
    fl_acc <= fl_acc | {fl_fc, fl_lp, fl_nc};
  end
  // status is only read with forcing off, so its force bit is expected low
  function automatic logic [31:0] st(logic [2:0] fl, logic [7:0] rq, logic [3:0] ac);
    return {11'h000, 1'b0, 1'b0, fl, rq, 4'h0, ac};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // holds the request until ready is sampled, then idles one cycle before the next setup
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("rdata", e, rdata);
  endtask
  task automatic pulse(input logic [7:0] m);
    pls <= m;
    @(posedge clk_sys);
    pls <= 8'h00;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic lev(input logic [7:0] m);
    lvl <= m;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic act(input logic [3:0] e);
    @(posedge clk_sys);
    chk("active", {28'h0, e}, {28'h0, active_group_index});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(GSL_OFS_STATUS, st(3'h0, 8'h00, 4'h1));
    apb(1'b1, GSL_OFS_FORCE, 32'h3);
    rd(GSL_OFS_STATUS, st(3'h4, 8'h00, 4'h1));
    apb(1'b1, GSL_OFS_CTRL, 32'h30);
    $display("defaults done");
    pulse(8'h04);
    act(4'h3);
    apb(1'b1, GSL_OFS_STATUS, 32'h00070000);
    pulse(8'h10);
    rd(GSL_OFS_STATUS, st(3'h1, 8'h00, 4'h3));
    apb(1'b1, GSL_OFS_STATUS, 32'h00070000);
    lev(8'h02);
    pulse(8'h04);
    rd(GSL_OFS_STATUS, st(3'h2, 8'h02, 4'h2));
    lev(8'h00);
    act(4'h2);
    pulse(8'h01);
    act(4'h1);
    pulse(8'h06);
    act(4'h2);
    lev(8'h02);
    apb(1'b1, GSL_OFS_REMOTE, 32'h3);
    act(4'h2);
    lev(8'h00);
    apb(1'b1, GSL_OFS_REMOTE, 32'h3);
    act(4'h3);
    $display("automatic selection done");
    apb(1'b1, GSL_OFS_CTRL, 32'h31);
    apb(1'b1, GSL_OFS_FORCE, 32'h1);
    act(4'h1);
    pulse(8'h02);
    act(4'h1);
    lev(8'h04);
    apb(1'b1, GSL_OFS_CTRL, 32'h30);
    act(4'h3);
    lev(8'h00);
    apb(1'b1, GSL_OFS_CTRL, 32'h31);
    apb(1'b1, GSL_OFS_FORCE, 32'h2);
    apb(1'b1, GSL_OFS_CTRL, 32'h30);
    act(4'h2);
    $display("forcing done");
    apb(1'b1, GSL_OFS_CTRL, 32'h80);
    lev(8'h80);
    act(4'h8);
    chk("default_load", 32'h000000fe, {24'h0, dl_acc});
    lev(8'hc0);
    act(4'h7);
    lev(8'h00);
    chk("fail pulses", 32'h7, {29'h0, fl_acc});
    apb(1'b0, 12'h010, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rerr});
    $display("limits done");
    print_verdict();
  end
endmodule // gsl_group_selector_bench
